/* adcs_pkg.sv */
/*
  Package for the area decoder and chip-select block: area codes, bus widths,
  memory types and the carrier structs.
  Assumes a single 125 MHz bus clock and a synchronous active-high reset.
*/
package adcs_pkg;

  localparam int ADDR_WIDTH = 32;
  localparam int AREA_MSB = 28;
  localparam int AREA_LSB = 26;

  // area codes on physical address bits 28..26
  localparam logic [2:0] AREA_CODE_0 = 3'h0;
  localparam logic [2:0] AREA_CODE_1 = 3'h1;
  localparam logic [2:0] AREA_CODE_7 = 3'h7;
  localparam int NUM_SELECTS = 7;

  // width codes, shared by the straps and the per-area control field
  localparam logic [1:0] WIDTH_PROHIBITED = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  // bit positions of the two-bit width fields of areas 2 to 6 in bus_control_two
  localparam int BC2_FIELD_BITS = 2;
  localparam int BC2_AREA2_POS = 4;
  localparam int BC2_WIDTH = 14;
  localparam logic [13:0] BC2_RESET = 14'h3FF0;

  localparam logic [2:0] AREA_SEL_RESET = 3'h0;
  localparam logic [6:0] SELECTS_IDLE = 7'h7F;
  localparam logic [3:0] LANES_IDLE = 4'hF;

  typedef enum logic [1:0] {
    ADCS_MEM_ORDINARY = 2'h0,
    ADCS_MEM_BURST_ROM = 2'h1,
    ADCS_MEM_SDRAM = 2'h2,
    ADCS_MEM_CARD = 2'h3
  } adcs_mem_type;

  typedef enum logic [1:0] {
    ADCS_ST_IDLE = 2'h0,
    ADCS_ST_ACCESS = 2'h1,
    ADCS_ST_RELEASED = 2'h2
  } adcs_state_type;

  // request from the core side
  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic [3:0] lanes;
    logic [31:0] addr;
  } adcs_req_type;

  // strobe pins, all active low
  typedef struct packed {
    logic [6:0] select_n;
    logic card_a_second_enable_n;
    logic card_b_second_enable_n;
    logic [3:0] lane_strobe_n;
    logic read_strobe_n;
  } adcs_pins_type;

endpackage

/* adcs_area_decode.sv */
/*
  Area decoder, chip-select and bus-width selector of the external bus
  controller. One access is held at a time; the core keeps its request
  stable until done pulses.
  Assumes pins in from outside the clock domain and core signals on mclk.
*/
module adcs_area_decode
  import adcs_pkg::*;
#(
  // wait lands two clocks late; below 3 a part that raises it once selected is missed
  parameter int WAIT_CYCLES = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire adcs_req_type req,
  input wire logic [BC2_WIDTH-1:0] bus_control_two,
  input wire adcs_mem_type [6:0] area_mem_type,
  input wire logic little_endian,
  input wire logic sdram_clock_on,
  input wire logic width_strap_high,
  input wire logic width_strap_low,
  input wire logic wait_n,
  input wire logic io16_n,
  input wire logic bus_release_request_n,
  output adcs_pins_type pins,
  output logic clock_enable,
  output logic bus_release_ack_n,
  output logic done,
  output logic [1:0] bus_width,
  output logic [2:0] area,
  output logic internal_hit,
  output logic reserved_hit
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    adcs_state_type state;
    logic [1:0] area0_width;
    logic strap_taken;
    logic [1:0] wait_sync;
    logic [1:0] io16_sync;
    logic [1:0] bus_release_request_sync;
    logic [2:0] area;
    logic [1:0] width;
    logic [3:0] count;
    adcs_pins_type pins;
    logic clock_enable;
    logic ack_n;
    logic done;
  } adcs_regs_type;

  adcs_regs_type r_reg;
  adcs_regs_type r_next;

  // width of an external area; area 0 from the straps, others from control
  function automatic logic [1:0] area_width(input logic [2:0] a,
                                            input logic [1:0] w0,
                                            input logic [BC2_WIDTH-1:0] bc);
    int pos;
    pos = BC2_AREA2_POS + (int'(a) - 2) * BC2_FIELD_BITS;
    if (a == AREA_CODE_0) begin
      return w0;
    end
    // area 7 has no width field; reading one would run off the vector
    if (a == AREA_CODE_7) begin
      return WIDTH_PROHIBITED;
    end
    return bc[pos+:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of the pending address; upper three bits never looked at
  logic [2:0] req_area;
  assign req_area = req.addr[AREA_MSB:AREA_LSB];

  // pins in: wait, 16-bit I/O and release request pass two flops first
  logic wait_s;
  logic io16_s;
  logic bus_release_request_s;
  assign wait_s = r_reg.wait_sync[1];
  assign io16_s = r_reg.io16_sync[1];
  assign bus_release_request_s = r_reg.bus_release_request_sync[1];

  always_comb begin
    adcs_mem_type mt;
    logic card;
    logic [3:0] ln;
    r_next = r_reg;
    mt = area_mem_type[r_reg.area];
    card = (mt == ADCS_MEM_CARD) && (r_reg.area >= 3'h5);
    ln = req.lanes;
    r_next.done = 1'b0;
    r_next.wait_sync = {r_reg.wait_sync[0], ~wait_n};
    r_next.io16_sync = {r_reg.io16_sync[0], ~io16_n};
    r_next.bus_release_request_sync = {r_reg.bus_release_request_sync[0], ~bus_release_request_n};
    r_next.clock_enable = sdram_clock_on;
    // strap caught on the first clocked cycle after reset release
    if (!r_reg.strap_taken) begin
      r_next.area0_width = {width_strap_high, width_strap_low};
      r_next.strap_taken = 1'b1;
    end
    case (r_reg.state)
      ADCS_ST_IDLE: begin
        r_next.pins.select_n = SELECTS_IDLE;
        r_next.pins.lane_strobe_n = LANES_IDLE;
        r_next.pins.read_strobe_n = 1'b1;
        r_next.pins.card_a_second_enable_n = 1'b1;
        r_next.pins.card_b_second_enable_n = 1'b1;
        // release takes priority over a new access while idle
        if (bus_release_request_s) begin
          r_next.state = ADCS_ST_RELEASED;
          r_next.ack_n = 1'b0;
        end else if (req.valid && r_reg.strap_taken && !r_reg.done) begin
          r_next.area = req_area;
          r_next.width = area_width(req_area, r_reg.area0_width, bus_control_two);
          r_next.count = 4'(WAIT_CYCLES);
          // internal and reserved areas drive no pin, finish at once
          if (req_area == AREA_CODE_1 || req_area == AREA_CODE_7) begin
            r_next.done = 1'b1;
          end else begin
            r_next.state = ADCS_ST_ACCESS;
            r_next.pins.select_n[req_area - ((req_area > AREA_CODE_0) ? 3'h1 : 3'h0)]
              = 1'b0;
          end
        end
      end
      ADCS_ST_ACCESS: begin
        r_next.pins.read_strobe_n = req.write;
        if (card) begin
          // second enable follows the upper byte lane (lane 1) of any card cycle, whatever its width
          if (r_reg.area == 3'h5) begin
            r_next.pins.card_a_second_enable_n = ~ln[1];
          end else begin
            r_next.pins.card_b_second_enable_n = ~ln[1];
          end
          r_next.pins.lane_strobe_n[2] = ~(req.io && !req.write);
          r_next.pins.lane_strobe_n[3] = ~(req.io && req.write);
          r_next.pins.lane_strobe_n[1:0] = {~req.write, 1'b1};
          // a card saying 16-bit I/O widens the cycle, little-endian only
          if (req.io && little_endian && io16_s) begin
            r_next.width = WIDTH_16;
          end
        end else if (mt == ADCS_MEM_SDRAM) begin
          r_next.pins.lane_strobe_n = ~ln;
        end else begin
          r_next.pins.lane_strobe_n = req.write ? ~ln : LANES_IDLE;
        end
        // extra wait states while the external device holds wait
        if (r_reg.count != 4'h0) begin
          r_next.count = r_reg.count - 4'h1;
        end else if (!wait_s) begin
          r_next.state = ADCS_ST_IDLE;
          r_next.done = 1'b1;
          r_next.pins.select_n = SELECTS_IDLE;
          r_next.pins.lane_strobe_n = LANES_IDLE;
          r_next.pins.read_strobe_n = 1'b1;
          r_next.pins.card_a_second_enable_n = 1'b1;
          r_next.pins.card_b_second_enable_n = 1'b1;
        end
      end
      ADCS_ST_RELEASED: begin
        if (!bus_release_request_s) begin
          r_next.state = ADCS_ST_IDLE;
          r_next.ack_n = 1'b1;
        end
      end
      default: begin
        r_next.state = ADCS_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // single state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      r_reg.state <= ADCS_ST_IDLE;
      r_reg.area0_width <= WIDTH_PROHIBITED;
      r_reg.strap_taken <= 1'b0;
      r_reg.wait_sync <= 2'h0;
      r_reg.io16_sync <= 2'h0;
      r_reg.bus_release_request_sync <= 2'h0;
      r_reg.area <= AREA_SEL_RESET;
      r_reg.width <= WIDTH_PROHIBITED;
      r_reg.count <= 4'h0;
      r_reg.pins <= {SELECTS_IDLE, 1'b1, 1'b1, LANES_IDLE, 1'b1};
      r_reg.clock_enable <= 1'b0;
      r_reg.ack_n <= 1'b1;
      r_reg.done <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops; hit flags decode the live request
  assign pins = r_reg.pins;
  assign clock_enable = r_reg.clock_enable;
  assign bus_release_ack_n = r_reg.ack_n;
  assign done = r_reg.done;
  assign bus_width = r_reg.width;
  assign area = r_reg.area;
  assign internal_hit = req.valid && (req_area == AREA_CODE_1);
  assign reserved_hit = req.valid && (req_area == AREA_CODE_7);

endmodule

/* adcs_far_model.sv */
/* far side model: a memory that may stretch cycles, a card
   assumes the pins of the area decoder on mclk */
module adcs_far_model
  import adcs_pkg::*;
(
  input wire logic mclk,
  input wire adcs_pins_type pins,
  input wire logic slow,
  input wire logic io16,
  output logic wait_n = 1'b1,
  output logic io16_n
);
  int hold = 0;
  // a slow part holds wait for three clocks once selected
  always @(posedge mclk) begin
    hold <= (pins.select_n == SELECTS_IDLE) ? 0 : hold + 1;
    wait_n <= !(slow && pins.select_n != SELECTS_IDLE && hold < 3);
  end
  // static port width of the card, pulled up when absent
  assign io16_n = !io16;
endmodule

/* adcs_area_decode_properties.sv */
/* checker on the decoder ports
   assumes a bind from the bench top */
module adcs_checker
  import adcs_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire adcs_req_type req,
  input wire adcs_pins_type pins,
  input wire logic clock_enable,
  input wire logic sdram_clock_on,
  input wire logic bus_release_ack_n,
  input wire logic done,
  input wire logic [2:0] area,
  input wire logic internal_hit,
  input wire logic reserved_hit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // start of an external access: idle pins, then a select low
  sequence s_take;
    req.valid && pins.select_n == SELECTS_IDLE ##1 pins.select_n != SELECTS_IDLE;
  endsequence
  AST_DONE_BOUND: assert property (s_take |-> ##[1:40] done)
    else $error("access did not complete");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done held too long");
  AST_INTERNAL: assert property (
    internal_hit == (req.valid && req.addr[28:26] == AREA_CODE_1))
    else $error("internal hit wrong");
  AST_SHADOW: assert property (
    reserved_hit == (req.valid && req.addr[28:26] == AREA_CODE_7))
    else $error("reserved hit wrong");
  AST_ONE_SELECT: assert property ($onehot0(~pins.select_n))
    else $error("two selects low");
  AST_AREA6: assert property (!pins.select_n[5] |-> area == 3'h6)
    else $error("area six select wrong");
  AST_CARD: assert property ((!pins.card_a_second_enable_n |-> !pins.select_n[4]) and
    (!pins.card_b_second_enable_n |-> !pins.select_n[5]))
    else $error("card enable without select");
  AST_READ: assert property (!pins.read_strobe_n |-> req.valid && !req.write)
    else $error("read strobe on write");
  AST_CKE: assert property ($past(!srst) |-> clock_enable == $past(sdram_clock_on))
    else $error("clock enable wrong");
  AST_ACK: assert property (!bus_release_ack_n |-> pins.select_n == SELECTS_IDLE)
    else $error("select while released");
endmodule

/* adcs_area_decode_tb.sv */
/* bench top: random accesses against an integer model
   assumes the package, design, far model and checker */
module adcs_area_decode_tb
  import adcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // enough programmed waits for the far part's wait to reach the decoder in time
  localparam int WAITS = 3;
  logic mclk = 0, srst = 1, le = 0, ck = 0, sh = 1, sl = 1, slow = 0, io16 = 0, brq_n = 1;
  logic wait_n, io16_n, ack_n, done, ih, rh, cke;
  logic [BC2_WIDTH-1:0] bc2 = BC2_RESET;
  logic [1:0] bw;
  logic [2:0] ar;
  adcs_req_type req = '0;
  adcs_mem_type [6:0] mt = '0;
  adcs_pins_type pins;
  int fails = 0, total_checks = 0, cyc = 0;
  adcs_area_decode #(.WAIT_CYCLES(WAITS)) adcs_area_decode_i (.mclk(mclk), .srst(srst),
    .req(req), .bus_control_two(bc2), .area_mem_type(mt), .little_endian(le),
    .sdram_clock_on(ck),
    .width_strap_high(sh), .width_strap_low(sl), .wait_n(wait_n), .io16_n(io16_n),
    .bus_release_request_n(brq_n), .pins(pins), .clock_enable(cke),
    .bus_release_ack_n(ack_n), .done(done), .bus_width(bw), .area(ar),
    .internal_hit(ih), .reserved_hit(rh));
  adcs_far_model adcs_far_model_i (.mclk(mclk), .pins(pins), .slow(slow), .io16(io16),
    .wait_n(wait_n), .io16_n(io16_n));
  always #4 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", s, e, v);
    end
  endtask
  // legal software setup: sdram 16/32, card 8/16; ports A/B unused, so 32 bits allowed
  task automatic cfg();
    for (int k = 2; k <= 6; k++) begin
      // areas 5 and 6 pick ordinary, burst ROM or card
      mt[k] = adcs_mem_type'(k < 4 ? 2 * ($urandom % 2) : k == 4 ? 0 :
        $urandom % 3 == 2 ? 3 : $urandom % 2);
      bc2[2*k+:2] = 2'(mt[k] == ADCS_MEM_SDRAM ? 2 + $urandom % 2 :
        mt[k] == ADCS_MEM_CARD ? 1 + $urandom % 2 : 1 + $urandom % 3);
    end
    if (mt[2] == ADCS_MEM_SDRAM && mt[3] == ADCS_MEM_SDRAM) bc2[7:6] = bc2[5:4];
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one access, strobes gathered until done
  task automatic acc(logic [31:0] a, logic w, logic io);
    int ea, ew, n;
    logic [6:0] sel;
    logic rd, ce, card;
    logic [1:0] ln;
    ea = a[28:26];
    card = mt[ea] == ADCS_MEM_CARD;
    ew = ea == 0 ? {sh, sl} : bc2[2*ea+:2];
    if (card && io && le && io16) ew = 2;
    {sel, rd, ce, ln} = '1;
    n = 0;
    @(posedge mclk);
    #1 req = '{1'b1, w, io, 4'($urandom), a};
    do begin
      @(posedge mclk);
      #1 n++;
      sel &= pins.select_n;
      rd &= pins.read_strobe_n;
      ce &= pins.card_a_second_enable_n & pins.card_b_second_enable_n;
      ln &= pins.lane_strobe_n[3:2];
    end while (done !== 1'b1 && n < 60);
    chk("done", 1, done);
    // a slow part stretches the cycle by the three clocks it holds wait
    chk("cycles", ea == 1 ? 1 : WAITS + 2 + (slow ? 3 : 0), n);
    chk("hits", ea == 1, {rh, ih});
    if (ea != 1) begin
      chk("area", ea, ar);
      chk("width", ew, bw);
      chk("select", 7'h7F ^ (32'h1 << (ea == 0 ? 0 : ea - 1)), sel);
      chk("card", !(card && req.lanes[1]), ce);
      if (!io) chk("read", w, rd);
      if (card && io) chk("iolane", {!w, w}, ln);
      if (mt[ea] == ADCS_MEM_SDRAM) chk("mask", 2'(~req.lanes[3:2]), ln);
      else if (!card) chk("lane", 2'(~({2{w}} & req.lanes[3:2])), ln);
    end
    req.valid = 0;
    chk("cke", ck, cke);
  endtask
  // release: acknowledge, requests held off, then given back
  task automatic rel();
    int n = 0;
    brq_n = 0;
    while (ack_n !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("ack", 0, ack_n);
    req.valid = 1;
    repeat (6) @(posedge mclk);
    #1 chk("refused", SELECTS_IDLE, pins.select_n);
    req.valid = 0;
    brq_n = 1;
    repeat (8) @(posedge mclk);
    #1 chk("ack", 1, ack_n);
  endtask
  initial begin
    void'($urandom(90483));
    for (int i = 0; i < 210; i++) begin
      if (i % 21 == 0) begin
        {sh, sl} = 2'(1 + i / 21 % 3);
        srst = 1;
        cfg();
        repeat (3) @(posedge mclk);
        #1 srst = 0;
      end
      {ck, le, io16, slow} = 4'($urandom);
      repeat (3) @(posedge mclk);
      // area 1 is reached through the uncached untranslated segment alias
      acc({(i % 7 == 1) ? 3'h5 : 3'($urandom), 3'(i % 7), 26'($urandom)}, 1'($urandom),
        1'($urandom));
    end
    rel();
    results();
  end
endmodule
bind adcs_area_decode adcs_checker adcs_checker_i (.mclk(mclk), .srst(srst), .req(req),
  .pins(pins), .clock_enable(clock_enable), .sdram_clock_on(sdram_clock_on),
  .bus_release_ack_n(bus_release_ack_n), .done(done), .area(area),
  .internal_hit(internal_hit), .reserved_hit(reserved_hit));
